// >>> fsal_limit_reg.sv
// write-once access limit register
`timescale 1ns/1ps
module fsal_limit_reg
   import fsal_pkg::*;
#(
   parameter int WIDTH = LIMIT_W
)
(
   // clock and reset
   input  wire logic             clock_in,
   input  wire logic             reset_in,
   input  wire logic             clk_en_in,
   // write side
   input  wire logic             write_in,
   input  wire logic [WIDTH-1:0] data_in,
   // state
   output logic      [WIDTH-1:0] value_out,
   output logic                  written_out
);
   initial
   begin
      if (WIDTH != LIMIT_W)
         $error("fsal_limit_reg: width must match the limit field");
   end

   // ==========================================================
   // first write after reset with clk_en_in high wins, the rest are dropped
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         value_out   <= ACCESS_LIMIT_RST;
         written_out <= 1'b0;
      end
      else if (clk_en_in && write_in && !written_out)
      begin
         value_out   <= data_in;
         written_out <= 1'b1;
      end
   end

   a_limit_once: assert property (@(posedge clock_in) disable iff (reset_in)
      written_out |=> ($stable(value_out) && written_out))
      else $error("access limit changed after first write");
endmodule : fsal_limit_reg

// >>> fsal_lock_store.sv
// flash lock byte store on the far side of the security block
`timescale 1ns/1ps
module fsal_lock_store
(
   // clock
   input  wire logic       clock_in,
   // programming side
   input  wire logic       prog_in,
   input  wire logic       prog_sel_in,
   input  wire logic [7:0] prog_data_in,
   input  wire logic       full_erase_in,
   // lock bytes
   output logic      [7:0] read_lock_out,
   output logic      [7:0] write_lock_out
);
   // ==========================================================
   // cells start erased, programming only clears bits
   initial
   begin
      read_lock_out = 8'hFF;
      write_lock_out = 8'hFF;
   end

   always @(posedge clock_in)
   begin
      if (full_erase_in)
         {read_lock_out, write_lock_out} <= 16'hFFFF;
      else if (prog_in && prog_sel_in)
         read_lock_out <= read_lock_out & prog_data_in;
      else if (prog_in)
         write_lock_out <= write_lock_out & prog_data_in;
   end
endmodule : fsal_lock_store

// >>> fsal_pkg.sv
// constants shared by the flash security and access limit block
package fsal_pkg;
   // ==========================================================
   // address geometry
   localparam int          ADDR_W            = 17;
   localparam int          BLOCK_SHIFT       = 14;
   localparam int          BLOCK_IDX_W       = 3;
   localparam int          SECTOR_SHIFT      = 10;
   localparam int          LIMIT_LOW_BITS    = 9;
   localparam int          LIMIT_W           = 8;
   // ==========================================================
   // register port
   localparam logic [7:0]  ACCESS_LIMIT_ADDR = 8'hB7;
   localparam logic [7:0]  ACCESS_LIMIT_RST  = 8'h00;
   localparam logic [7:0]  READ_ZERO         = 8'h00;
   // ==========================================================
   // lock byte placement per memory size
   localparam logic [16:0] WE_LOCK_ADDR_128K = 17'h1FBFE;
   localparam logic [16:0] RD_LOCK_ADDR_128K = 17'h1FBFF;
   localparam logic [16:0] WE_LOCK_ADDR_64K  = 17'h0FFFE;
   localparam logic [16:0] RD_LOCK_ADDR_64K  = 17'h0FFFF;
   localparam logic [2:0]  LOCK_BLOCK_BIT_128K = 3'h7;
   localparam logic [2:0]  LOCK_BLOCK_BIT_64K  = 3'h3;
   localparam logic [7:0]  LOCK_ALL_CLEAR    = 8'h00;
   // ==========================================================
   // operation codes
   typedef enum logic [1:0] {
      FSAL_OP_READ,
      FSAL_OP_WRITE,
      FSAL_OP_ERASE,
      FSAL_OP_EXEC
   } fsal_op_t;
endpackage : fsal_pkg

// >>> fsal_tb.sv
// self-checking bench for the flash security and access limit block
`timescale 1ns/1ps
module tb;
   import fsal_pkg::*;
   // ==========================================================
   // design and partner signals
   logic              clock_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1;
   logic              sfr_write_in = 1'b0, sfr_read_in = 1'b0;
   logic [7:0]        sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out;
   logic [2:0]        en = 3'h0;
   logic              cpu_req_in = 1'b0, jtag_req_in = 1'b0, jtag_scratch_in = 1'b0;
   logic [1:0]        cpu_op_in = 2'h0, jtag_op_in = 2'h0;
   logic [ADDR_W-1:0] cpu_addr_in = '0, cpu_pc_in = '0, jtag_addr_in = '0, limit_addr;
   logic              cpu_grant, cpu_deny, cpu_dv, jtag_grant, jtag_deny, jtag_dv, full_erase, limit_written;
   logic [7:0]        read_lock, write_lock, prog_data = 8'h00;
   logic              prog = 1'b0, prog_sel = 1'b0;
   // ==========================================================
   // reference model state
   logic [16:0]       lim = '0;
   logic              wr = 1'b0;
   logic [7:0]        rl = 8'hFF, wl = 8'hFF;
   logic [2:0]        ec = '0;
   logic [3:0]        ej = '0;
   int                num_errors = 0, checks = 0, seed;

   always #50 clock_in = ~clock_in;

   fsal_top fsal_top_inst (.clock_in(clock_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
      .sfr_write_in(sfr_write_in), .sfr_read_in(sfr_read_in), .sfr_addr_in(sfr_addr_in),
      .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
      .program_store_write_enable_in(en[2]), .program_store_erase_enable_in(en[1]),
      .flash_write_erase_enable_in(en[0]), .cpu_req_in(cpu_req_in), .cpu_op_in(cpu_op_in),
      .cpu_addr_in(cpu_addr_in), .cpu_pc_in(cpu_pc_in), .cpu_grant_out(cpu_grant),
      .cpu_deny_out(cpu_deny), .cpu_data_valid_out(cpu_dv), .jtag_req_in(jtag_req_in),
      .jtag_op_in(jtag_op_in), .jtag_addr_in(jtag_addr_in), .jtag_scratch_in(jtag_scratch_in),
      .jtag_grant_out(jtag_grant), .jtag_deny_out(jtag_deny), .jtag_data_valid_out(jtag_dv),
      .full_erase_out(full_erase), .read_lock_in(read_lock), .write_lock_in(write_lock),
      .access_limit_address_out(limit_addr), .limit_written_out(limit_written));

   fsal_lock_store fsal_lock_store_inst (.clock_in(clock_in), .prog_in(prog), .prog_sel_in(prog_sel),
      .prog_data_in(prog_data), .full_erase_in(full_erase), .read_lock_out(read_lock),
      .write_lock_out(write_lock));

   // ==========================================================
   // expected core answer {grant, deny, data valid}; en = {write, erase, flash}
   function automatic logic [2:0] exp_cpu(logic [1:0] op, logic [16:0] a, pc, logic [2:0] e);
      logic up_low;
      logic g;
      up_low = (pc >= lim) && (a < lim);
      g = 1'b1;
      if (op == FSAL_OP_READ)
         return {2'b10, !up_low};
      if (op == FSAL_OP_EXEC)
         return 3'b101;
      if (op == FSAL_OP_WRITE)
         g = e[2] && e[0] && !up_low;
      if (op == FSAL_OP_ERASE)
         g = (&e) && !up_low && (a[16:10] != WE_LOCK_ADDR_128K[16:10]);
      return {g, !g, 1'b0};
   endfunction : exp_cpu

   // expected jtag answer {grant, deny, data valid, full erase}
   function automatic logic [3:0] exp_jtag(logic [1:0] op, logic [16:0] a, logic s);
      logic [2:0] bi;
      logic       g;
      if (!s && (a == WE_LOCK_ADDR_128K || a == RD_LOCK_ADDR_128K) && op != FSAL_OP_EXEC)
         return (op == FSAL_OP_ERASE) ? 4'h9 : {2'b10, op == FSAL_OP_READ, 1'b0};
      bi = (a[16:10] == WE_LOCK_ADDR_128K[16:10]) ? LOCK_BLOCK_BIT_128K : a[16:14];
      if (op == FSAL_OP_READ || op == FSAL_OP_EXEC)
         g = s ? (rl != 8'h00) : rl[bi];
      else
         g = s ? (wl != 8'h00) : wl[bi];
      return {g, !g, g && op == FSAL_OP_READ, 1'b0};
   endfunction : exp_jtag

   // ==========================================================
   // shared tasks
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // compares the previous cycle's answers, then presents the next requests
   task automatic step(input logic cv, input logic [1:0] co, input logic [16:0] ca, cp, input logic jv,
                       input logic [1:0] jo, input logic [16:0] ja, input logic js, input logic [2:0] e);
      @(negedge clock_in);
      check(cpu_grant, ec[2]);
      check(cpu_deny, ec[1]);
      check(cpu_dv, ec[0]);
      check(jtag_grant, ej[3]);
      check(jtag_deny, ej[2]);
      check(jtag_dv, ej[1]);
      check(full_erase, ej[0]);
      {cpu_req_in, cpu_op_in, cpu_addr_in, cpu_pc_in, en} = {cv, co, ca, cp, e};
      {jtag_req_in, jtag_op_in, jtag_addr_in, jtag_scratch_in} = {jv, jo, ja, js};
      ec = cv ? exp_cpu(co, ca, cp, e) : 3'h0;
      ej = jv ? exp_jtag(jo, ja, js) : 4'h0;
      if (ej[0])
         {rl, wl} = 16'hFFFF;
   endtask : step

   task automatic cpu(input logic [1:0] op, input logic [16:0] a, pc, input logic [2:0] e);
      step(1'b1, op, a, pc, 1'b0, 2'h0, 17'h00000, 1'b0, e);
   endtask : cpu

   task automatic jtg(input logic [1:0] op, input logic [16:0] a, input logic s);
      step(1'b0, 2'h0, 17'h00000, 17'h00000, 1'b1, op, a, s, 3'h0);
   endtask : jtg

   task automatic idle;
      step(1'b0, 2'h0, 17'h00000, 17'h00000, 1'b0, 2'h0, 17'h00000, 1'b0, 3'h0);
   endtask : idle

   task automatic sfr_wr(input logic [7:0] a, d);
      @(negedge clock_in);
      {sfr_write_in, sfr_addr_in, sfr_wdata_in} = {1'b1, a, d};
      if (a == ACCESS_LIMIT_ADDR && !wr && clk_en_in)
         {wr, lim} = {1'b1, d, 9'h000};
      @(negedge clock_in);
      sfr_write_in = 1'b0;
   endtask : sfr_wr

   task automatic sfr_rd(input logic [7:0] a, exp);
      @(negedge clock_in);
      {sfr_read_in, sfr_addr_in} = {1'b1, a};
      @(negedge clock_in);
      sfr_read_in = 1'b0;
      check(sfr_rdata_out, exp);
      check(limit_addr, lim);
      check(limit_written, wr);
   endtask : sfr_rd

   task automatic lock_set(input logic [7:0] r, w);
      @(negedge clock_in);
      {prog, prog_sel, prog_data} = {2'b11, r};
      @(negedge clock_in);
      {prog_sel, prog_data} = {1'b0, w};
      @(negedge clock_in);
      prog = 1'b0;
      {rl, wl} = {rl & r, wl & w};
   endtask : lock_set

   task automatic do_reset;
      @(negedge clock_in);
      reset_in = 1'b1;
      repeat (4) @(negedge clock_in);
      reset_in = 1'b0;
      {lim, wr, ec, ej} = '0;
   endtask : do_reset

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   // ==========================================================
   // tests
   initial
   begin
      #500000;
      num_errors++;
      complete_run;
   end

   initial
   begin
      seed = $urandom(32);
      do_reset;
      sfr_rd(ACCESS_LIMIT_ADDR, ACCESS_LIMIT_RST);
      sfr_wr(8'hB6, 8'h55);
      sfr_rd(8'hB6, READ_ZERO);
      cpu(FSAL_OP_READ, 17'h00000, 17'h1FFFF, 3'h0);
      idle;
      $display("test reset_values done");
      sfr_wr(ACCESS_LIMIT_ADDR, 8'h40);
      sfr_wr(ACCESS_LIMIT_ADDR, 8'h80);
      sfr_rd(ACCESS_LIMIT_ADDR, 8'h40);
      $display("test write_once done");
      for (int i = 0; i < 16; i++)
         cpu(2'(i), i[2] ? lim : lim - 17'h1, i[3] ? lim : lim - 17'h1, 3'h7);
      for (int i = 0; i < 16; i++)
         cpu(i[3] ? FSAL_OP_ERASE : FSAL_OP_WRITE, 17'h10000, 17'h00000, 3'(i));
      cpu(FSAL_OP_ERASE, 17'h1F800, 17'h00000, 3'h7);
      cpu(FSAL_OP_WRITE, RD_LOCK_ADDR_128K, 17'h00000, 3'h7);
      for (int i = 0; i < 300; i++)
         cpu(2'($urandom), 17'($urandom), 17'($urandom), 3'($urandom));
      idle;
      $display("test core_access done");
      lock_set(8'hF7, 8'h7F);
      for (int b = 0; b < 8; b++)
      begin
         jtg(FSAL_OP_READ, {3'(b), 14'h0123}, 1'b0);
         jtg(FSAL_OP_WRITE, {3'(b), 14'h0123}, 1'b0);
      end
      jtg(FSAL_OP_WRITE, 17'h1F800, 1'b0);
      jtg(FSAL_OP_READ, RD_LOCK_ADDR_128K, 1'b0);
      jtg(FSAL_OP_WRITE, WE_LOCK_ADDR_128K, 1'b0);
      jtg(FSAL_OP_READ, 17'h00000, 1'b1);
      jtg(FSAL_OP_ERASE, RD_LOCK_ADDR_128K, 1'b0);
      idle;
      jtg(FSAL_OP_ERASE, 17'h1F800, 1'b0);
      for (int k = 0; k < 12; k++)
      begin
         jtg(FSAL_OP_ERASE, WE_LOCK_ADDR_128K, 1'b0);
         idle;
         lock_set(k[0] ? 8'h00 : 8'($urandom), k[1] ? 8'h00 : 8'($urandom));
         for (int i = 0; i < 40; i++)
            step(1'b1, 2'($urandom), 17'($urandom), 17'($urandom), 1'b1, 2'($urandom),
                 17'($urandom), 1'($urandom), 3'($urandom));
         idle;
      end
      $display("test jtag_locks done");
      do_reset;
      clk_en_in = 1'b0;
      sfr_wr(ACCESS_LIMIT_ADDR, 8'h33);
      clk_en_in = 1'b1;
      sfr_rd(ACCESS_LIMIT_ADDR, 8'h00);
      cpu(FSAL_OP_READ, 17'h00000, 17'h1FFFF, 3'h0);
      idle;
      sfr_wr(ACCESS_LIMIT_ADDR, 8'h41);
      sfr_rd(ACCESS_LIMIT_ADDR, 8'h41);
      for (int i = 0; i < 50; i++)
         cpu(2'($urandom), 17'($urandom), 17'($urandom), 3'($urandom));
      idle;
      $display("test second_reset done");
      complete_run;
   end
endmodule : tb

// >>> fsal_top.sv
// flash security lock and access limit checker
// Functional notes
// - software write/erase needs enable bits set
// - each lock bit guards one 16k block
// - read lock bit zero blocks JTAG reads
// - write lock bit zero blocks JTAG write/erase
// - scratchpad locked only when whole byte zero
// - lock byte addresses depend on memory size
// - software may write, never erase, lock sector
// - read-locked data undefined, no JTAG debug
// - lock bytes always readable and writable
// - lock block guarded by bit 7 or 3
// - unlocked lock page may be JTAG erased
// - JTAG erase at lock byte erases all
// - full erase only from JTAG, never firmware
// - limit splits memory into lower and upper
// - upper code reading lower gets garbage
// - lower code reads everything freely
// - upper code cannot write/erase lower
// - limit is 8 MSBs, 9 zero LSBs
// - limit register is write-once per reset
// - reset limit zero opens all memory
`timescale 1ns/1ps
module fsal_top
   import fsal_pkg::*;
#(
   parameter bit VARIANT_128K = 1'b1
)
(
   // clock, reset, enable
   input  wire logic              clock_in,
   input  wire logic              reset_in,
   input  wire logic              clk_en_in,
   // special register port
   input  wire logic              sfr_write_in,
   input  wire logic              sfr_read_in,
   input  wire logic [7:0]        sfr_addr_in,
   input  wire logic [7:0]        sfr_wdata_in,
   output logic      [7:0]        sfr_rdata_out,
   // software enable bits
   input  wire logic              program_store_write_enable_in,
   input  wire logic              program_store_erase_enable_in,
   input  wire logic              flash_write_erase_enable_in,
   // processor core requests
   input  wire logic              cpu_req_in,
   input  wire logic [1:0]        cpu_op_in,
   input  wire logic [ADDR_W-1:0] cpu_addr_in,
   input  wire logic [ADDR_W-1:0] cpu_pc_in,
   output logic                   cpu_grant_out,
   output logic                   cpu_deny_out,
   output logic                   cpu_data_valid_out,
   // jtag requests
   input  wire logic              jtag_req_in,
   input  wire logic [1:0]        jtag_op_in,
   input  wire logic [ADDR_W-1:0] jtag_addr_in,
   input  wire logic              jtag_scratch_in,
   output logic                   jtag_grant_out,
   output logic                   jtag_deny_out,
   output logic                   jtag_data_valid_out,
   output logic                   full_erase_out,
   // lock bytes held in flash
   input  wire logic [7:0]        read_lock_in,
   input  wire logic [7:0]        write_lock_in,
   // state
   output logic [ADDR_W-1:0]      access_limit_address_out,
   output logic                   limit_written_out
);
   // ==========================================================
   // variant constants
   localparam logic [16:0] WE_LOCK_ADDR   = VARIANT_128K ? WE_LOCK_ADDR_128K : WE_LOCK_ADDR_64K;
   localparam logic [16:0] RD_LOCK_ADDR   = VARIANT_128K ? RD_LOCK_ADDR_128K : RD_LOCK_ADDR_64K;
   localparam logic [2:0]  LOCK_BLOCK_BIT = VARIANT_128K ? LOCK_BLOCK_BIT_128K : LOCK_BLOCK_BIT_64K;

   initial
   begin
      if (ADDR_W != BLOCK_SHIFT + BLOCK_IDX_W)
         $error("fsal_top: block index does not cover the address");
   end

   // ==========================================================
   // access limit register
   logic [LIMIT_W-1:0] access_limit_register;
   logic [ADDR_W-1:0]  access_limit_address;
   logic               limit_wr;

   assign limit_wr = sfr_write_in && (sfr_addr_in == ACCESS_LIMIT_ADDR);

   fsal_limit_reg #(
      .WIDTH       (LIMIT_W)
   ) u_limit (
      .clock_in    (clock_in),
      .reset_in    (reset_in),
      .clk_en_in   (clk_en_in),
      .write_in    (limit_wr),
      .data_in     (sfr_wdata_in),
      .value_out   (access_limit_register),
      .written_out (limit_written_out)
   );

   // reset value zero puts the limit at address zero
   assign access_limit_address = {access_limit_register, {LIMIT_LOW_BITS{1'b0}}};

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
         sfr_rdata_out <= READ_ZERO;
      else if (clk_en_in && sfr_read_in)
         sfr_rdata_out <= (sfr_addr_in == ACCESS_LIMIT_ADDR) ? access_limit_register : READ_ZERO;
   end

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
         access_limit_address_out <= {ADDR_W{1'b0}};
      else if (clk_en_in)
         access_limit_address_out <= access_limit_address;
   end

   // ==========================================================
   // processor side decision
   logic cpu_tgt_lower;
   logic cpu_pc_upper;
   logic cpu_cross;
   logic cpu_lock_sector;
   logic cpu_ok;
   logic cpu_valid;

   assign cpu_tgt_lower   = cpu_addr_in < access_limit_address;
   assign cpu_pc_upper    = cpu_pc_in >= access_limit_address;
   assign cpu_cross       = cpu_pc_upper && cpu_tgt_lower;
   assign cpu_lock_sector = (cpu_addr_in[ADDR_W-1:SECTOR_SHIFT] == WE_LOCK_ADDR[ADDR_W-1:SECTOR_SHIFT]);

   always_comb
   begin
      cpu_ok    = 1'b0;
      cpu_valid = 1'b0;
      case (cpu_op_in)
         FSAL_OP_EXEC:
         begin
            cpu_ok    = 1'b1;
            cpu_valid = 1'b1;
         end
         FSAL_OP_READ:
         begin
            cpu_ok    = 1'b1;
            cpu_valid = !cpu_cross;
         end
         FSAL_OP_WRITE:
            cpu_ok = program_store_write_enable_in
                  && flash_write_erase_enable_in
                  && !cpu_cross;
         FSAL_OP_ERASE:
            cpu_ok = program_store_write_enable_in
                  && program_store_erase_enable_in
                  && flash_write_erase_enable_in
                  && !cpu_lock_sector
                  && !cpu_cross;
         default:
         begin
            cpu_ok    = 1'b0;
            cpu_valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         cpu_grant_out      <= 1'b0;
         cpu_deny_out       <= 1'b0;
         cpu_data_valid_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         cpu_grant_out      <= cpu_req_in && cpu_ok;
         cpu_deny_out       <= cpu_req_in && !cpu_ok;
         cpu_data_valid_out <= cpu_req_in && cpu_ok && cpu_valid;
      end
   end

   // ==========================================================
   // jtag side decision
   logic [BLOCK_IDX_W-1:0] jtag_blk;
   logic                   jtag_is_lock_byte;
   logic                   jtag_lock_sector;
   logic                   jtag_rd_locked;
   logic                   jtag_wr_locked;
   logic                   jtag_ok;
   logic                   jtag_full;

   assign jtag_is_lock_byte = (jtag_addr_in == WE_LOCK_ADDR) || (jtag_addr_in == RD_LOCK_ADDR);
   assign jtag_lock_sector  = (jtag_addr_in[ADDR_W-1:SECTOR_SHIFT] == WE_LOCK_ADDR[ADDR_W-1:SECTOR_SHIFT]);
   // lock sector follows its own guard bit, other addresses their block
   assign jtag_blk          = jtag_lock_sector ? LOCK_BLOCK_BIT
                                               : jtag_addr_in[ADDR_W-1:BLOCK_SHIFT];

   always_comb
   begin
      if (jtag_scratch_in)
      begin
         jtag_rd_locked = (read_lock_in == LOCK_ALL_CLEAR);
         jtag_wr_locked = (write_lock_in == LOCK_ALL_CLEAR);
      end
      else
      begin
         jtag_rd_locked = !read_lock_in[jtag_blk];
         jtag_wr_locked = !write_lock_in[jtag_blk];
      end
   end

   always_comb
   begin
      jtag_ok   = 1'b0;
      jtag_full = 1'b0;
      case (jtag_op_in)
         FSAL_OP_READ:
            jtag_ok = (jtag_is_lock_byte && !jtag_scratch_in) || !jtag_rd_locked;
         FSAL_OP_WRITE:
            jtag_ok = (jtag_is_lock_byte && !jtag_scratch_in) || !jtag_wr_locked;
         FSAL_OP_ERASE:
         begin
            if (jtag_is_lock_byte && !jtag_scratch_in)
            begin
               jtag_ok   = 1'b1;
               jtag_full = 1'b1;
            end
            else
               jtag_ok = !jtag_wr_locked;
         end
         FSAL_OP_EXEC:
            jtag_ok = !jtag_rd_locked;
         default:
         begin
            jtag_ok   = 1'b0;
            jtag_full = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         jtag_grant_out      <= 1'b0;
         jtag_deny_out       <= 1'b0;
         jtag_data_valid_out <= 1'b0;
         full_erase_out      <= 1'b0;
      end
      else if (clk_en_in)
      begin
         jtag_grant_out      <= jtag_req_in && jtag_ok;
         jtag_deny_out       <= jtag_req_in && !jtag_ok;
         // locked read data is flagged undefined
         jtag_data_valid_out <= jtag_req_in && jtag_ok && (jtag_op_in == FSAL_OP_READ);
         full_erase_out      <= jtag_req_in && jtag_full;
      end
   end

   // ==========================================================
   // checks
   a_cpu_write_enable: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && cpu_req_in && cpu_op_in == FSAL_OP_WRITE && !program_store_write_enable_in)
      |=> (cpu_deny_out && !cpu_grant_out))
      else $error("software write taken without write enable");

   a_cpu_erase_enable: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && cpu_req_in && cpu_op_in == FSAL_OP_ERASE
       && !(program_store_erase_enable_in && flash_write_erase_enable_in))
      |=> cpu_deny_out)
      else $error("software erase taken without erase enable");

   a_lock_sector_erase: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && cpu_req_in && cpu_op_in == FSAL_OP_ERASE
       && cpu_addr_in[ADDR_W-1:SECTOR_SHIFT] == WE_LOCK_ADDR[ADDR_W-1:SECTOR_SHIFT])
      |=> !cpu_grant_out)
      else $error("software erased the lock byte sector");

   a_cpu_cross_read: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && cpu_req_in && cpu_op_in == FSAL_OP_READ
       && cpu_pc_in >= access_limit_address && cpu_addr_in < access_limit_address)
      |=> (cpu_grant_out && !cpu_data_valid_out))
      else $error("upper code read lower partition data");

   a_cpu_lower_read: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && cpu_req_in && cpu_op_in == FSAL_OP_READ && cpu_pc_in < access_limit_address)
      |=> cpu_data_valid_out)
      else $error("lower code read refused");

   a_cpu_cross_write: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && cpu_req_in && cpu_op_in != FSAL_OP_READ && cpu_op_in != FSAL_OP_EXEC
       && cpu_pc_in >= access_limit_address && cpu_addr_in < access_limit_address)
      |=> cpu_deny_out)
      else $error("upper code altered lower partition");

   a_jtag_read_lock: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && jtag_req_in && jtag_op_in == FSAL_OP_READ && !jtag_scratch_in
       && !jtag_is_lock_byte && !read_lock_in[jtag_addr_in[ADDR_W-1:BLOCK_SHIFT]])
      |=> (jtag_deny_out && !jtag_data_valid_out))
      else $error("jtag read of read-locked block");

   a_jtag_write_lock: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && jtag_req_in && jtag_op_in == FSAL_OP_WRITE && !jtag_scratch_in
       && !jtag_is_lock_byte && !write_lock_in[jtag_addr_in[ADDR_W-1:BLOCK_SHIFT]])
      |=> jtag_deny_out)
      else $error("jtag write of write-locked block");

   a_scratch_lock: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && jtag_req_in && jtag_scratch_in && jtag_op_in == FSAL_OP_READ
       && read_lock_in != LOCK_ALL_CLEAR)
      |=> jtag_grant_out)
      else $error("scratchpad read refused with lock byte not clear");

   a_lock_byte_access: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && jtag_req_in && !jtag_scratch_in && jtag_addr_in == RD_LOCK_ADDR
       && jtag_op_in != FSAL_OP_EXEC)
      |=> jtag_grant_out)
      else $error("lock byte access refused");

   a_full_erase: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && jtag_req_in && jtag_op_in == FSAL_OP_ERASE && !jtag_scratch_in
       && jtag_addr_in == WE_LOCK_ADDR)
      |=> (full_erase_out && jtag_grant_out))
      else $error("erase at lock byte did not erase all");

   a_full_erase_src: assert property (@(posedge clock_in) disable iff (reset_in)
      (full_erase_out && $past(clk_en_in)) |-> $past(jtag_req_in))
      else $error("full erase without jtag request");

   a_lock_page_erase: assert property (@(posedge clock_in) disable iff (reset_in)
      (clk_en_in && jtag_req_in && jtag_op_in == FSAL_OP_ERASE && !jtag_scratch_in
       && jtag_lock_sector && !jtag_is_lock_byte && write_lock_in[LOCK_BLOCK_BIT])
      |=> (jtag_grant_out && !full_erase_out))
      else $error("unlocked lock page erase refused");

   a_limit_split: assert property (@(posedge clock_in) disable iff (reset_in)
      ($past(clk_en_in) && !$past(reset_in))
      |-> (access_limit_address_out == {$past(access_limit_register), {LIMIT_LOW_BITS{1'b0}}}))
      else $error("limit address output not formed from register");

   a_limit_reset: assert property (@(posedge clock_in)
      $past(reset_in) |-> (access_limit_address == {ADDR_W{1'b0}}))
      else $error("limit not zero after reset");
endmodule : fsal_top
